/* src/msd_decoder.sv */
// memory space decoder top: registered target strobes
//
// Functional notes
// - program 0000..3FFF selects flash
// - program 0000..007F is vector area
// - program 3F80..3FFF holds chip control bits
// - external space only via external move
// - external 0000..02A7 selects external RAM
// - 02A8..02EF (controller on), 4020..40FF select extended registers
// - external 0300..031D selects converter results
// - external RAM 768 or 680 bytes
// - internal 00..1F are four register banks
// - internal 20..7F general RAM, both kinds
// - internal 20..2F bit addressable
// - indirect 80..FF selects upper RAM
// - direct 80..FF selects function registers
// - function regs ending 0/8 bit addressable
// - control regs split internal and external
`timescale 1ns/10ps
`include "msd_regs.svh"
module msd_decoder
	import msd_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// core request
	input wire logic reqValid,
	input wire logic reqWrite,
	input wire logic [15:0] reqAddr,
	input wire msd_space_e reqSpace,
	input wire logic reqIndirect,
	input wire logic reqExtMove,
	input wire logic [7:0] reqWdata,
	// configuration level from the controller block
	input wire logic piEnable,
	// target read data
	input wire logic [7:0] tgtRdata,
	// target strobes
	output logic selFlash_q,
	output logic selBank_q,
	output logic selIram_q,
	output logic selUpper_q,
	output logic selSfr_q,
	output logic selXram_q,
	output logic selXreg_q,
	output logic selAdc_q,
	output logic tgtWrite_q,
	output logic [15:0] tgtAddr_q,
	output logic [7:0] tgtWdata_q,
	// attributes
	output logic bitAddr_q,
	output logic vecArea_q,
	output logic ctrlArea_q,
	// answer to core
	output logic [7:0] rspRdata_q,
	output logic rspValid_q
);
	msd_target_e target; // combinational choice
	msd_space_e effSpace; // space after the move check
	logic bitAddr, vecArea, ctrlArea;
	logic [7:0] sel; // one-hot strobe vector
	logic [7:0] sel_d, sel_q;
	logic tgtWrite_d, bitAddr_d, vecArea_d, ctrlArea_d;
	logic [15:0] tgtAddr_d;
	logic [7:0] tgtWdata_d, rspRdata_d;
	logic rspValid_d;
	logic unmapped_q, unmapped_d; // previous access hit nothing

	// external space without the move instruction is refused
	always_comb begin
		if (reqSpace == SP_EXTERNAL && !reqExtMove) begin
			effSpace = msd_space_e'(2'h3);
		end else begin
			effSpace = reqSpace;
		end
	end

	// shared selection logic
	msd_target_sel uSel (
		.addr(reqAddr),
		.space(effSpace),
		.indirect(reqIndirect),
		.piEnable(piEnable),
		.target(target),
		.bitAddr(bitAddr),
		.vecArea(vecArea),
		.ctrlArea(ctrlArea)
	);

	// one-hot decode of the target, one bit per strobe
	for (genvar i = 0; i < 8; i++) begin : gSel
		// strobe index i belongs to enum code i + 1, cut to the enum width
		assign sel[i] = reqValid && (target == msd_target_e'(4'(i + 1)));
	end

	// next values of the strobes and the answer
	always_comb begin
		sel_d = sel;
		tgtWrite_d = reqValid && reqWrite && (target != TG_NONE);
		tgtAddr_d = reqAddr;
		tgtWdata_d = reqWdata;
		bitAddr_d = reqValid && bitAddr;
		vecArea_d = reqValid && vecArea;
		ctrlArea_d = reqValid && ctrlArea;
		unmapped_d = reqValid && (target == TG_NONE);
		rspValid_d = reqValid;
		// read data for the access taken last cycle
		if (unmapped_q) begin
			rspRdata_d = 8'h00;
		end else begin
			rspRdata_d = tgtRdata;
		end
	end

	// registers
	always_ff @(posedge mclk) begin
		if (reset) begin
			sel_q <= 8'h00;
			tgtWrite_q <= 1'b0;
			tgtAddr_q <= 16'h0000;
			tgtWdata_q <= 8'h00;
			bitAddr_q <= 1'b0;
			vecArea_q <= 1'b0;
			ctrlArea_q <= 1'b0;
			unmapped_q <= 1'b0;
			rspValid_q <= 1'b0;
			rspRdata_q <= 8'h00;
		end else begin
			sel_q <= sel_d;
			tgtWrite_q <= tgtWrite_d;
			tgtAddr_q <= tgtAddr_d;
			tgtWdata_q <= tgtWdata_d;
			bitAddr_q <= bitAddr_d;
			vecArea_q <= vecArea_d;
			ctrlArea_q <= ctrlArea_d;
			unmapped_q <= unmapped_d;
			rspValid_q <= rspValid_d;
			rspRdata_q <= rspRdata_d;
		end
	end

	// strobe outputs straight from flops
	assign selFlash_q = sel_q[0];
	assign selBank_q = sel_q[1];
	assign selIram_q = sel_q[2];
	assign selUpper_q = sel_q[3];
	assign selSfr_q = sel_q[4];
	assign selXram_q = sel_q[5];
	assign selXreg_q = sel_q[6];
	assign selAdc_q = sel_q[7];

	// checks: at most one strobe per cycle
	AST_ONEHOT: assert property (@(posedge mclk) disable iff (reset)
		$onehot0(sel_q)) else $error("more than one target");
	// every access taken is answered one cycle later
	AST_RSPV: assert property (@(posedge mclk) disable iff (reset)
		reqValid |=> rspValid_q) else $error("access not answered");

	// program space
	AST_FLASH: assert property (@(posedge mclk) disable iff (reset)
		reqValid && reqSpace == SP_PROG && reqAddr <= 16'h3FFF
		|=> selFlash_q) else $error("flash not selected");
	AST_VEC: assert property (@(posedge mclk) disable iff (reset)
		vecArea_q |-> selFlash_q && tgtAddr_q <= 16'h007F)
		else $error("vector flag wrong");
	AST_CTRL: assert property (@(posedge mclk) disable iff (reset)
		ctrlArea_q |-> selFlash_q && tgtAddr_q >= 16'h3F80)
		else $error("control flag wrong");

	// external space
	AST_NOMOVE: assert property (@(posedge mclk) disable iff (reset)
		reqValid && reqSpace == SP_EXTERNAL && !reqExtMove
		|=> sel_q == 8'h00) else $error("external without move");
	AST_XRAM: assert property (@(posedge mclk) disable iff (reset)
		selXram_q |-> tgtAddr_q <= 16'h02FF)
		else $error("external RAM out of range");
	AST_ADC: assert property (@(posedge mclk) disable iff (reset)
		selAdc_q |-> tgtAddr_q >= 16'h0300 && tgtAddr_q <= 16'h031D)
		else $error("result area out of range");
	// extended registers live in two separate windows
	AST_XREG: assert property (@(posedge mclk) disable iff (reset)
		selXreg_q |-> (tgtAddr_q >= 16'h02A8 && tgtAddr_q <= 16'h02EF) ||
		(tgtAddr_q >= 16'h4020 && tgtAddr_q <= 16'h40FF))
		else $error("extended register out of range");
	// controller on: its window is registers, not RAM
	AST_PIXREG: assert property (@(posedge mclk) disable iff (reset)
		reqValid && reqSpace == SP_EXTERNAL && reqExtMove && piEnable &&
		reqAddr >= 16'h02A8 && reqAddr <= 16'h02EF
		|=> selXreg_q) else $error("controller window not registers");

	// internal space
	AST_BANK: assert property (@(posedge mclk) disable iff (reset)
		reqValid && reqSpace == SP_INTERNAL && reqAddr[7:0] <= 8'h1F
		|=> selBank_q) else $error("register bank not selected");
	AST_IRAM: assert property (@(posedge mclk) disable iff (reset)
		reqValid && reqSpace == SP_INTERNAL && reqAddr[7:0] >= 8'h20 &&
		!reqAddr[7] |=> selIram_q)
		else $error("internal RAM not selected");
	AST_BITRAM: assert property (@(posedge mclk) disable iff (reset)
		selIram_q && bitAddr_q |-> tgtAddr_q[7:0] <= 8'h2F)
		else $error("bit access outside bit area");
	AST_UPPER: assert property (@(posedge mclk) disable iff (reset)
		reqValid && reqSpace == SP_INTERNAL && reqAddr[7] && reqIndirect
		|=> selUpper_q) else $error("indirect upper not RAM");
	AST_SFR: assert property (@(posedge mclk) disable iff (reset)
		reqValid && reqSpace == SP_INTERNAL && reqAddr[7] && !reqIndirect
		|=> selSfr_q) else $error("direct upper not SFR");
	// function registers: bit flag exactly on low nibble 0 or 8
	AST_BITSFR: assert property (@(posedge mclk) disable iff (reset)
		selSfr_q |-> bitAddr_q == (tgtAddr_q[2:0] == 3'h0))
		else $error("function register bit flag wrong");

	// unmapped accesses: no write leaves, read data is zero
	AST_NOWR: assert property (@(posedge mclk) disable iff (reset)
		tgtWrite_q |-> sel_q != 8'h00) else $error("write without target");
	// read data lags the strobe by one cycle
	AST_ZERO: assert property (@(posedge mclk) disable iff (reset)
		$past(unmapped_q) |-> rspRdata_q == 8'h00)
		else $error("unmapped read not zero");

	// main scenarios
	COV_XREG: cover property (@(posedge mclk) selXreg_q);
	COV_BITSFR: cover property (@(posedge mclk) selSfr_q && bitAddr_q);
	COV_UNMAP: cover property (@(posedge mclk) unmapped_q);
	COV_VEC: cover property (@(posedge mclk) selFlash_q && vecArea_q);
	COV_UPPER: cover property (@(posedge mclk) selUpper_q);
endmodule

/* src/msd_pkg.sv */
// types of the memory space decoder
package msd_pkg;
	// data space kinds seen by the core
	typedef enum logic [1:0] {
		SP_PROG,
		SP_INTERNAL,
		SP_EXTERNAL
	} msd_space_e;
	// selected target
	typedef enum logic [3:0] {
		TG_NONE,
		TG_FLASH,
		TG_BANK,
		TG_IRAM,
		TG_UPPER,
		TG_SFR,
		TG_XRAM,
		TG_XREG,
		TG_ADC
	} msd_target_e;
endpackage

/* src/msd_regs.svh */
// address map constants of the memory space decoder
`ifndef MSD_REGS_SVH
`define MSD_REGS_SVH
`define MSD_PROG_LAST 16'h3FFF
`define MSD_VEC_LAST 16'h007F
`define MSD_CTRL_FIRST 16'h3F80
`define MSD_XRAM_LAST 16'h02A7
`define MSD_XRAM_FULL_LAST 16'h02FF
`define MSD_XREG1_FIRST 16'h02A8
`define MSD_XREG1_LAST 16'h02EF
`define MSD_XREG2_FIRST 16'h4020
`define MSD_XREG2_LAST 16'h40FF
`define MSD_ADC_FIRST 16'h0300
`define MSD_ADC_LAST 16'h031D
`define MSD_BANK_LAST 8'h1F
`define MSD_BIT_FIRST 8'h20
`define MSD_BIT_LAST 8'h2F
`define MSD_UPPER_FIRST 8'h80
`endif

/* src/msd_target_sel.sv */
// combinational address to target selection
`timescale 1ns/10ps
`include "msd_regs.svh"
module msd_target_sel
	import msd_pkg::*;
(
	// request
	input wire logic [15:0] addr,
	input wire msd_space_e space,
	input wire logic indirect,
	input wire logic piEnable,
	// answer
	output msd_target_e target,
	output logic bitAddr,
	output logic vecArea,
	output logic ctrlArea
);
	// one target per access, from address, space, kind and controller level only
	always_comb begin
		target = TG_NONE;
		bitAddr = 1'b0;
		vecArea = 1'b0;
		ctrlArea = 1'b0;
		case (space)
			SP_PROG: begin
				// flash window
				if (addr <= `MSD_PROG_LAST) begin
					target = TG_FLASH;
					vecArea = (addr <= `MSD_VEC_LAST);
					ctrlArea = (addr >= `MSD_CTRL_FIRST);
				end
			end
			SP_INTERNAL: begin
				// only the low byte counts internally
				if (addr[7:0] <= `MSD_BANK_LAST) begin
					target = TG_BANK;
				end else if (addr[7:0] < `MSD_UPPER_FIRST) begin
					target = TG_IRAM;
					bitAddr = (addr[7:0] <= `MSD_BIT_LAST);
				end else if (indirect) begin
					target = TG_UPPER;
				end else begin
					target = TG_SFR;
					bitAddr = (addr[2:0] == 3'h0);
				end
			end
			SP_EXTERNAL: begin
				// only reached by the external data move
				if (piEnable && addr >= `MSD_XREG1_FIRST &&
					addr <= `MSD_XREG1_LAST) begin
					target = TG_XREG;
				end else if (piEnable ? addr <= `MSD_XRAM_LAST
					: addr <= `MSD_XRAM_FULL_LAST) begin
					target = TG_XRAM;
				end else if (addr >= `MSD_ADC_FIRST &&
					addr <= `MSD_ADC_LAST) begin
					target = TG_ADC;
				end else if (addr >= `MSD_XREG2_FIRST &&
					addr <= `MSD_XREG2_LAST) begin
					target = TG_XREG;
				end
			end
			default: begin
				target = TG_NONE;
			end
		endcase
	end
endmodule

/* tb/msd_decoder_tb.sv */
// testbench of the memory space decoder
`timescale 1ns/10ps
`define CHK(n, e, a) begin samplesChecked++; if ((a) !== (e)) begin \
miscompares++; $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module msd_decoder_tb;
	import msd_pkg::*;
	logic mclk = 0, reset = 1, reqValid = 0, reqWrite = 0, reqIndirect = 0;
	logic reqExtMove = 0, piEnable = 0, tgtWrite, bitAddr, vecArea;
	logic ctrlArea, rspValid;
	logic [15:0] reqAddr = 16'h0000, tgtAddr;
	logic [7:0] reqWdata = 8'h00, tgtRdata, sel, tgtWdata, rspRdata;
	msd_space_e reqSpace = SP_PROG;
	int miscompares = 0, samplesChecked = 0;
	// 50 MHz clock
	always #10 mclk = ~mclk;
	msd_decoder uut (.mclk(mclk), .reset(reset), .reqValid(reqValid),
		.reqWrite(reqWrite), .reqAddr(reqAddr), .reqSpace(reqSpace),
		.reqIndirect(reqIndirect), .reqExtMove(reqExtMove),
		.reqWdata(reqWdata), .piEnable(piEnable), .tgtRdata(tgtRdata),
		.selFlash_q(sel[7]), .selBank_q(sel[6]), .selIram_q(sel[5]),
		.selUpper_q(sel[4]), .selSfr_q(sel[3]), .selXram_q(sel[2]),
		.selXreg_q(sel[1]), .selAdc_q(sel[0]), .tgtWrite_q(tgtWrite),
		.tgtAddr_q(tgtAddr), .tgtWdata_q(tgtWdata), .bitAddr_q(bitAddr),
		.vecArea_q(vecArea), .ctrlArea_q(ctrlArea), .rspRdata_q(rspRdata),
		.rspValid_q(rspValid));
	msd_target_model partner (.mclk(mclk), .anySel(|sel),
		.tgtAddr(tgtAddr), .tgtRdata(tgtRdata));
	// expected target from space, address and addressing kind
	function automatic msd_target_e expTgt(msd_space_e s, logic [15:0] a,
		logic ind, logic ext);
		if (s == SP_PROG) return (a <= 16'h3FFF) ? TG_FLASH : TG_NONE;
		if (s == SP_INTERNAL) begin
			if (a[7:0] <= 8'h1F) return TG_BANK;
			if (a[7:0] <= 8'h7F) return TG_IRAM;
			return ind ? TG_UPPER : TG_SFR;
		end
		if (!ext) return TG_NONE;
		if (a <= 16'h02A7) return TG_XRAM;
		if (a <= 16'h02FF) begin
			if (!piEnable) return TG_XRAM;
			return (a <= 16'h02EF) ? TG_XREG : TG_NONE;
		end
		if (a >= 16'h0300 && a <= 16'h031D) return TG_ADC;
		if (a >= 16'h4020 && a <= 16'h40FF) return TG_XREG;
		return TG_NONE;
	endfunction
	// one access: drive one cycle, judge strobes, then read data
	task automatic acc(msd_space_e s, logic [15:0] a, logic ind, logic ext,
		logic wr);
		msd_target_e t;
		logic [7:0] e;
		logic [7:0] rd;
		logic [7:0] expRd;
		logic b;
		@(posedge mclk);
		// expectations once any earlier mode change has landed
		t = expTgt(s, a, ind, ext);
		e = (t == TG_NONE) ? 8'h00 : (8'h80 >> (t - 1));
		b = s == SP_INTERNAL && ((a[7:0] >= 8'h20 && a[7:0] <= 8'h2F) ||
			(t == TG_SFR && a[2:0] == 3'h0));
		expRd = (t == TG_NONE) ? 8'h00 : a[7:0] ^ 8'hA5;
		reqValid <= 1'b1;
		reqSpace <= s;
		reqAddr <= a;
		reqIndirect <= ind;
		reqExtMove <= ext;
		reqWrite <= wr;
		reqWdata <= a[7:0] ^ 8'h3C;
		@(posedge mclk);
		reqValid <= 1'b0;
		#1;
		`CHK("strobes", e, sel)
		`CHK("write", wr && t != TG_NONE, tgtWrite)
		`CHK("vector", s == SP_PROG && a <= 16'h007F, vecArea)
		`CHK("control", s == SP_PROG && a >= 16'h3F80 && t != TG_NONE,
			ctrlArea)
		`CHK("bitaddr", b, bitAddr)
		if (t != TG_NONE) `CHK("addr", a, tgtAddr)
		if (wr && t != TG_NONE) `CHK("wdata", a[7:0] ^ 8'h3C, tgtWdata)
		if (!wr) `CHK("rspvalid", 1'b1, rspValid)
		@(posedge mclk);
		#1;
		rd = rspRdata;
		if (!wr) `CHK("rdata", expRd, rd)
	endtask
	// reset raised mid-run with a write pending: nothing may leave
	task automatic t_reset;
		@(posedge mclk);
		reset <= 1'b1;
		reqValid <= 1'b1;
		reqSpace <= SP_PROG;
		reqAddr <= 16'h0000;
		reqWrite <= 1'b1;
		@(posedge mclk);
		@(posedge mclk);
		reset <= 1'b0;
		reqValid <= 1'b0;
		#1;
		`CHK("rstsel", 8'h00, sel)
		`CHK("rstwr", 1'b0, tgtWrite)
		`CHK("rstrsp", 1'b0, rspValid)
		@(posedge mclk);
		#1;
		`CHK("relsel", 8'h00, sel)
	endtask
	// program space edges of vector, user and control sectors
	task automatic t_program;
		logic [15:0] al [7] = '{16'h0000, 16'h007F, 16'h0080, 16'h3F7F,
			16'h3F80, 16'h3FFF, 16'h4000};
		foreach (al[i]) acc(SP_PROG, al[i], 1'b0, 1'b0, 1'b0);
	endtask
	// internal space, direct and indirect, reads and writes
	task automatic t_internal;
		logic [7:0] al [10] = '{8'h00, 8'h1F, 8'h20, 8'h2F, 8'h30, 8'h7F,
			8'h80, 8'h88, 8'h8F, 8'hFF};
		foreach (al[i]) begin
			acc(SP_INTERNAL, {8'h00, al[i]}, 1'b0, 1'b0, i[0]);
			acc(SP_INTERNAL, {8'h00, al[i]}, 1'b1, 1'b0, ~i[0]);
		end
	endtask
	// external space with the controller off and on
	task automatic t_external;
		logic [15:0] al [13] = '{16'h0000, 16'h02A7, 16'h02A8, 16'h02EF,
			16'h02F0, 16'h02FF, 16'h0300, 16'h031D, 16'h031E, 16'h401F,
			16'h4020, 16'h40FF, 16'hFFFF};
		for (int p = 0; p < 2; p++) begin
			@(posedge mclk);
			piEnable <= p[0];
			foreach (al[i]) begin
				acc(SP_EXTERNAL, al[i], 1'b0, 1'b1, 1'b0);
				acc(SP_EXTERNAL, al[i], 1'b0, 1'b1, 1'b1);
				acc(SP_EXTERNAL, al[i], 1'b0, 1'b0, i[0]);
			end
		end
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", samplesChecked, miscompares);
		if (miscompares == 0 && samplesChecked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge mclk);
		reset <= 1'b0;
		#1;
		`CHK("reset", 8'h00, sel)
		`CHK("rstvalid", 1'b0, rspValid)
		`CHK("rstrdata", 8'h00, rspRdata)
		t_program();
		t_internal();
		t_reset();
		t_external();
		print_verdict();
	end
	// watchdog against a hung run
	initial begin
		repeat (3000) @(posedge mclk);
		miscompares++;
		print_verdict();
	end
endmodule

/* tb/msd_target_model.sv */
// target side model: answers reads of whatever target is strobed
`timescale 1ns/10ps
module msd_target_model (
	// clock
	input wire logic mclk,
	// strobes and address
	input wire logic anySel,
	input wire logic [15:0] tgtAddr,
	// read data
	output logic [7:0] tgtRdata
);
	logic [7:0] last_q = 8'h00; // last byte returned
	// pattern byte while selected, inverse of last byte once released
	always_comb begin
		tgtRdata = anySel ? (tgtAddr[7:0] ^ 8'hA5) : ~last_q;
	end
	always_ff @(posedge mclk) begin
		if (anySel) last_q <= tgtRdata;
	end
endmodule
